// ### bench/gtrsc_bench.sv
`timescale 1ns/100ps
`default_nettype none
module gtrsc_bench;
    import gtrsc_pkg::*;
    localparam int unsigned LAG = 20;
    localparam int unsigned PFL = 10;
    logic pclk;
    logic presetn = 1'b0;
    logic [AW-1:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    gtrsc_chan_in_t chan_in [NCH];
    gtrsc_peer_in_t peer_in;
    gtrsc_peer_out_t peer_out;
    logic power_low = 1'b0;
    logic fault_halt = 1'b0;
    logic slow = 1'b0;
    logic [NGRP-1:0] cancel_req = 16'h0;
    logic [NMOD-1:0] present_set = 16'h0003;
    logic [NCH-1:0] sync_active;
    logic [NCH-1:0] sync_master;
    logic [32:0] exp_q [$];
    int err_total = 0;
    int n_checks = 0;
    logic [15:0] pv;
    logic [15:0] rt0;
    logic [15:0] rt1;
    logic [3:0] act;
    logic [3:0] mst;
    logic [32:0] lvl;
    gtrsc_top #(.LAG_CYC(LAG), .PFAIL_CYC(PFL)) uut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_in(chan_in), .peer_in(peer_in), .power_low(power_low),
        .fault_halt(fault_halt), .peer_out(peer_out), .sync_active(sync_active),
        .sync_master(sync_master));
    gtrsc_peer_model peer (.pclk(pclk), .presetn(presetn), .peer_out(peer_out), .slow(slow),
        .cancel_req(cancel_req), .present_set(present_set), .peer_in(peer_in));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    task automatic cancel(input int c);
        @(posedge pclk);
        case (c)
            0: apb(OFF_CFG_BASE + 8'h4, 1'b1, 32'h0000_0001);
            1: apb(OFF_CFG_BASE + 8'h4, 1'b1, 32'h0000_0601);
            2: apb(OFF_CFG_BASE + 8'h4, 1'b1, 32'h0000_0A01);
            3: apb(OFF_CFG_BASE + 8'h4, 1'b1, 32'h0000_0301);
            4: chan_in[1].underscale <= 1'b1;
            5: chan_in[1].overscale <= 1'b1;
            6: chan_in[1].burnout <= 1'b1;
            7: chan_in[1].measured_value <= 16'h7FFF;
            8: fault_halt <= 1'b1;
            9: power_low <= 1'b1;
            10: cancel_req <= 16'h0002;
            default: present_set <= 16'h0007;
        endcase
        repeat (PFL + 6) @(posedge pclk);
        chan_in[1] <= '{pv, 1'b0, 1'b0, 1'b0, rt1};
        fault_halt <= 1'b0;
        power_low <= 1'b0;
        cancel_req <= 16'h0;
        apb(OFF_CFG_BASE + 8'h4, 1'b1, 32'h0000_0201);
    endtask : cancel
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        finish_test();
    end
    initial begin
        logic [2:0] ct;
        int c;
        void'($urandom(73835));
        foreach (chan_in[i]) chan_in[i] = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CFG_BASE, 33'h0);
        rd(OFF_ERR_BASE, {1'b0, ERR_HI_RST, ERR_LO_RST});
        rd(8'h80, 33'h1_0000_0000);
        rd(8'h02, 33'h1_0000_0000);
        for (int k = 0; k < 15; k++) begin
            ct = (k < 8) ? k[2:0] : 3'h0;
            c = (k < 5) ? k : ((k >= 8) ? k - 3 : 0);
            pv = 16'($urandom_range(999, 100));
            rt0 = 16'($urandom);
            rt1 = 16'($urandom);
            slow <= k[0];
            chan_in[0] <= '{pv, 1'b0, 1'b0, 1'b0, rt0};
            chan_in[1] <= '{pv, 1'b0, 1'b0, 1'b0, rt1};
            apb(OFF_SV_BASE, 1'b1, {16'h0, (ct == 3'h1) ? pv - 16'h0032 : pv + 16'h03E8});
            apb(OFF_SV_BASE + 8'h4, 1'b1, {16'h0, pv + 16'h03E8});
            apb(OFF_CFG_BASE, 1'b1, {20'h0, 4'h2, ct, 5'h01});
            apb(OFF_CFG_BASE + 8'h4, 1'b1, 32'h0000_0201);
            repeat (12) @(posedge pclk);
            apb(OFF_CTRL, 1'b1, 32'h0000_0001);
            repeat (LAG + 12) @(posedge pclk);
            act = (ct < 3'h5) ? 4'h3 : 4'h0;
            mst = (act == 4'h0) ? 4'h0 : ((rt1 > rt0) ? 4'h2 : 4'h1);
            rd(OFF_STATUS, {25'h0, mst, act});
            lvl = {1'b0, 14'h3FFF, act[0], 1'b0, 8'h0, mst, act};
            check({1'b0, peer_out.ready, 8'h0, sync_master, sync_active}, lvl);
            cancel(c);
            repeat (LAG + 8) @(posedge pclk);
            rd(OFF_STATUS, 33'h0);
            check({29'h0, sync_active}, 33'h0);
        end
        for (int j = 0; j < 2; j++) begin
            apb(OFF_CFG_BASE, 1'b1, (j == 0) ? 32'h0000_0211 : 32'h0000_0200);
            apb(OFF_CFG_BASE + 8'h4, 1'b1, (j == 0) ? 32'h0000_0201 : 32'h0000_0200);
            repeat (12) @(posedge pclk);
            apb(OFF_CTRL, 1'b1, 32'h0000_0001);
            repeat (LAG + 12) @(posedge pclk);
            rd(OFF_STATUS, 33'h0);
        end
        finish_test();
    end
endmodule : gtrsc_bench
bind gtrsc_top gtrsc_chk #(.LAG_CYC(LAG_CYC), .PFAIL_CYC(PFAIL_CYC)) chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_low(power_low), .fault_halt(fault_halt), .sync_active(sync_active),
    .sync_master(sync_master));
`default_nettype wire

// ### bench/gtrsc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module gtrsc_chk
    import gtrsc_pkg::*;
#(
    parameter int unsigned LAG_CYC = 20,
    parameter int unsigned PFAIL_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_low,
    input wire logic fault_halt,
    input wire logic [NCH-1:0] sync_active,
    input wire logic [NCH-1:0] sync_master
);
    logic [15:0] since_q;
    logic [15:0] since_d;
    logic [15:0] dip_q;
    logic [15:0] dip_d;
    // Cycles since last start write, length of supply dip
    always_comb begin
        since_d = (since_q == 16'hFFFF) ? since_q : since_q + 16'h1;
        if (psel && penable && pready && pwrite && paddr == OFF_CTRL && pwdata[0]) begin
            since_d = 16'h0;
        end
        dip_d = !power_low ? 16'h0 : ((dip_q == 16'hFFFF) ? dip_q : dip_q + 16'h1);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_q <= 16'hFFFF;
            dip_q <= 16'h0;
        end else begin
            since_q <= since_d;
            dip_q <= dip_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_reset_quiet: assert property ($rose(presetn) |-> !pready && ~|sync_active)
        else $error("outputs not quiet after reset");
    chk_pready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_pready_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("answer not in second access cycle");
    chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    chk_master_in_rise: assert property (~|(sync_master & ~sync_active))
        else $error("master without rise");
    chk_halt_stop: assert property (fault_halt [*4] |-> ~|sync_active)
        else $error("rise survives fault halt");
    chk_dip_stop: assert property (dip_q > PFAIL_CYC + 4 |-> ~|sync_active)
        else $error("rise survives supply dip");
    chk_rise_lag: assert property ($rose(|sync_active) |->
        since_q >= LAG_CYC && since_q <= LAG_CYC + 8)
        else $error("rise not one lag after start");
endmodule : gtrsc_chk
`default_nettype wire

// ### bench/gtrsc_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
module gtrsc_peer_model
    import gtrsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire gtrsc_peer_out_t peer_out,
    input wire logic slow,
    input wire logic [NGRP-1:0] cancel_req,
    input wire logic [NMOD-1:0] present_set,
    output gtrsc_peer_in_t peer_in
);
    logic [NGRP-1:0] lag_q [8];
    logic [NGRP-1:0] lag_d [8];
    // Link delay line for peer readiness
    always_comb begin
        lag_d[0] = peer_out.ready;
        for (int i = 1; i < 8; i++) begin
            lag_d[i] = lag_q[i - 1];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lag_q <= '{default: 16'h0};
        end else begin
            lag_q <= lag_d;
        end
    end
    always_comb begin
        peer_in.ready = slow ? lag_q[7] : lag_q[0];
        peer_in.cancel = cancel_req;
        peer_in.master = 16'h0;
        peer_in.present = present_set;
    end
endmodule : gtrsc_peer_model
`default_nettype wire

// ### design/gtrsc_chan_check.sv
`timescale 1ns/100ps
`default_nettype none

module gtrsc_chan_check
    import gtrsc_pkg::*;
(
    input wire gtrsc_cfg_t cfg,
    input wire logic signed [DW-1:0] set_value,
    input wire logic signed [DW-1:0] err_hi,
    input wire logic signed [DW-1:0] err_lo,
    input wire gtrsc_chan_in_t chan,
    output logic qual,
    output logic cancel_cond,
    output logic reached
);

    logic mode_ok;
    logic type_ok;
    logic direct;
    logic input_ok;
    logic dir_ok;

    assign mode_ok = cfg.run && !cfg.autotuning && !cfg.manual;
    assign type_ok = (cfg.ctype inside {CT_PID_REVERSE, CT_PID_DIRECT, CT_HC_AIR,
                      CT_HC_WATER, CT_HC_LINEAR}) && !cfg.pband_zero;
    assign direct = (cfg.ctype == CT_PID_DIRECT);
    assign input_ok = !chan.underscale && !chan.overscale && !chan.burnout
                      && (chan.measured_value <= err_hi)
                      && (chan.measured_value >= err_lo);
    // Heat/cool falls in the rising branch only
    assign dir_ok = direct ? (set_value < chan.measured_value)
                           : (set_value > chan.measured_value);

    assign qual = mode_ok && type_ok && input_ok && dir_ok
                  && (cfg.group != 4'h0)
                  && !cfg.learn;

    // Error points themselves count as abnormal during a rise
    assign cancel_cond = !cfg.run || cfg.autotuning || cfg.manual
                         || cfg.pband_zero
                         || chan.underscale || chan.overscale || chan.burnout
                         || (chan.measured_value >= err_hi)
                         || (chan.measured_value <= err_lo);

    assign reached = direct ? (chan.measured_value <= set_value)
                            : (chan.measured_value >= set_value);

endmodule : gtrsc_chan_check

`default_nettype wire

// ### design/gtrsc_pkg.sv
package gtrsc_pkg;

    // Sizes
    localparam int NCH = 4;
    localparam int NGRP = 16;
    localparam int NMOD = 16;
    localparam int DW = 16;
    localparam int AW = 8;

    // Register offsets
    localparam logic [AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [AW-1:0] OFF_STATUS = 8'h04;
    localparam logic [AW-1:0] OFF_CFG_BASE = 8'h10;
    localparam logic [AW-1:0] OFF_SV_BASE = 8'h20;
    localparam logic [AW-1:0] OFF_ERR_BASE = 8'h30;
    localparam logic [AW-1:0] OFF_BLOCK_MASK = 8'hF0;

    // Field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CFG_W = 12;
    localparam int ST_ACTIVE_LSB = 0;
    localparam int ST_MASTER_LSB = 4;
    localparam int ST_ARMING_BIT = 8;
    localparam int ST_PFAIL_BIT = 9;
    localparam int ST_HALT_BIT = 10;
    localparam int ERR_HI_LSB = 16;

    // Values after reset
    localparam logic [CFG_W-1:0] CFG_RST = 12'h000;
    localparam logic [DW-1:0] SV_RST = 16'h0000;
    localparam logic [DW-1:0] ERR_HI_RST = 16'h7FFF;
    localparam logic [DW-1:0] ERR_LO_RST = 16'h8000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int LAG_MS = 250;
    localparam int PFAIL_MS = 4;
    localparam int LAG_CYCLES = LAG_MS * (CLK_HZ / 1000);
    localparam int PFAIL_CYCLES = PFAIL_MS * (CLK_HZ / 1000);
    localparam int LAG_CW = 23;
    localparam int PF_CW = 17;

    typedef enum logic [2:0] {
        CT_PID_REVERSE,
        CT_PID_DIRECT,
        CT_HC_AIR,
        CT_HC_WATER,
        CT_HC_LINEAR,
        CT_OTHER_5,
        CT_OTHER_6,
        CT_OTHER_7
    } gtrsc_ctype_t;

    typedef struct packed {
        logic manual;
        logic autotuning;
        logic run;
        logic pband_zero;
        gtrsc_ctype_t ctype;
        logic learn;
        logic [3:0] group;
    } gtrsc_cfg_t;

    typedef struct packed {
        logic signed [DW-1:0] measured_value;
        logic underscale;
        logic overscale;
        logic burnout;
        logic [DW-1:0] rise_time;
    } gtrsc_chan_in_t;

    typedef struct packed {
        logic [NGRP-1:0] ready;
        logic [NGRP-1:0] cancel;
        logic [NGRP-1:0] master;
        logic [NMOD-1:0] present;
    } gtrsc_peer_in_t;

    typedef struct packed {
        logic [NGRP-1:0] ready;
        logic [NGRP-1:0] cancel;
    } gtrsc_peer_out_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARM,
        ST_RISE
    } gtrsc_state_t;

endpackage : gtrsc_pkg

// ### design/gtrsc_top.sv
// Notes on behaviour
// - Group starts only when all members qualify
// - Nonzero group number needed to qualify
// - Learning setting must be zero
// - Control type PID or heat/cool PID
// - Input healthy and within error points
// - Set value on correct side at start
// - Heat/cool rises only upward
// - Slowest channel of group becomes master
// - Any member cancel stops whole group
// - Cancelled slave returns to normal control
// - Stop, autotuning or manual cancels
// - Proportional band zero cancels
// - Bad or out-of-range input cancels
// - Supply dip beyond 4 ms cancels
// - Fault-halt state cancels
// - Module insertion or removal cancels
// - Peer status awaited over 250 ms lag
// - Up to 16 peer modules tracked
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module gtrsc_top
    import gtrsc_pkg::*;
#(
    parameter int unsigned LAG_CYC = LAG_CYCLES,
    parameter int unsigned PFAIL_CYC = PFAIL_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire gtrsc_chan_in_t chan_in [NCH],
    input wire gtrsc_peer_in_t peer_in,
    input wire logic power_low,
    input wire logic fault_halt,
    output gtrsc_peer_out_t peer_out,
    output logic [NCH-1:0] sync_active,
    output logic [NCH-1:0] sync_master
);

    // Register file
    gtrsc_cfg_t cfg_q [NCH];
    gtrsc_cfg_t cfg_d [NCH];
    logic [DW-1:0] sv_q [NCH];
    logic [DW-1:0] sv_d [NCH];
    logic [DW-1:0] err_hi_q [NCH];
    logic [DW-1:0] err_hi_d [NCH];
    logic [DW-1:0] err_lo_q [NCH];
    logic [DW-1:0] err_lo_d [NCH];
    logic start_q;
    logic start_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;

    // Sequencing state
    gtrsc_state_t st_q [NCH];
    gtrsc_state_t st_d [NCH];
    logic [NCH-1:0] master_q;
    logic [NCH-1:0] master_d;
    logic [LAG_CW-1:0] lag_cnt_q;
    logic [LAG_CW-1:0] lag_cnt_d;
    logic [PF_CW-1:0] pf_cnt_q;
    logic [PF_CW-1:0] pf_cnt_d;
    logic [NMOD-1:0] present_q;
    logic [NMOD-1:0] present_d;
    logic halt_q;
    logic halt_d;
    gtrsc_peer_out_t peer_out_q;
    gtrsc_peer_out_t peer_out_d;
    logic [NCH-1:0] active_q;
    logic [NCH-1:0] active_d;

    // Per-channel checks
    logic [NCH-1:0] qual;
    logic [NCH-1:0] cancel_cond;
    logic [NCH-1:0] reached;

    // Group summaries
    logic [NGRP-1:0] local_ok;
    logic [NGRP-1:0] grp_ok;
    logic [NGRP-1:0] local_cancel;
    logic [NGRP-1:0] grp_cancel;
    logic [NGRP-1:0] grp_reached;
    logic pf_long;
    logic mod_change;
    logic global_cancel;
    logic any_arm;
    logic lag_done;
    logic [NCH-1:0] is_master;

    // Bus decode
    logic setup_acc;
    logic wr_en;
    logic [1:0] sel_ch;
    logic [3:0] sel_blk;
    logic hit;

    for (genvar c = 0; c < NCH; c++) begin : g_chk
        gtrsc_chan_check u_chk (
            .cfg(cfg_q[c]),
            .set_value(sv_q[c]),
            .err_hi(err_hi_q[c]),
            .err_lo(err_lo_q[c]),
            .chan(chan_in[c]),
            .qual(qual[c]),
            .cancel_cond(cancel_cond[c]),
            .reached(reached[c])
        );
    end

    // APB slave, one wait state
    assign setup_acc = psel && penable && !pready_q;
    assign wr_en = psel && penable && pready_q && pwrite;
    assign sel_ch = paddr[3:2];
    assign sel_blk = paddr[7:4];
    assign hit = (paddr[1:0] == 2'b00)
                 && ((paddr == OFF_CTRL) || (paddr == OFF_STATUS)
                     || ((paddr & OFF_BLOCK_MASK) == OFF_CFG_BASE)
                     || ((paddr & OFF_BLOCK_MASK) == OFF_SV_BASE)
                     || ((paddr & OFF_BLOCK_MASK) == OFF_ERR_BASE));

    always_comb begin
        pready_d = setup_acc;
        pslverr_d = setup_acc && !hit;
        prdata_d = prdata_q;
        start_d = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            cfg_d[c] = cfg_q[c];
            sv_d[c] = sv_q[c];
            err_hi_d[c] = err_hi_q[c];
            err_lo_d[c] = err_lo_q[c];
        end
        if (setup_acc) begin
            prdata_d = RDATA_RST;
            if (!pwrite && hit) begin
                if (paddr == OFF_STATUS) begin
                    prdata_d[ST_ACTIVE_LSB +: NCH] = active_q;
                    prdata_d[ST_MASTER_LSB +: NCH] = master_q;
                    prdata_d[ST_ARMING_BIT] = any_arm;
                    prdata_d[ST_PFAIL_BIT] = pf_long;
                    prdata_d[ST_HALT_BIT] = halt_q;
                end else if (sel_blk == OFF_CFG_BASE[7:4]) begin
                    prdata_d[CFG_W-1:0] = cfg_q[sel_ch];
                end else if (sel_blk == OFF_SV_BASE[7:4]) begin
                    prdata_d[DW-1:0] = sv_q[sel_ch];
                end else if (sel_blk == OFF_ERR_BASE[7:4]) begin
                    prdata_d[DW-1:0] = err_lo_q[sel_ch];
                    prdata_d[ERR_HI_LSB +: DW] = err_hi_q[sel_ch];
                end
            end
        end
        if (wr_en && hit) begin
            if (paddr == OFF_CTRL) begin
                start_d = pwdata[CTRL_START_BIT];
            end else if (sel_blk == OFF_CFG_BASE[7:4]) begin
                cfg_d[sel_ch] = gtrsc_cfg_t'(pwdata[CFG_W-1:0]);
            end else if (sel_blk == OFF_SV_BASE[7:4]) begin
                sv_d[sel_ch] = pwdata[DW-1:0];
            end else if (sel_blk == OFF_ERR_BASE[7:4]) begin
                err_lo_d[sel_ch] = pwdata[DW-1:0];
                err_hi_d[sel_ch] = pwdata[ERR_HI_LSB +: DW];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= RDATA_RST;
            start_q <= 1'b0;
            for (int c = 0; c < NCH; c++) begin
                cfg_q[c] <= gtrsc_cfg_t'(CFG_RST);
                sv_q[c] <= SV_RST;
                err_hi_q[c] <= ERR_HI_RST;
                err_lo_q[c] <= ERR_LO_RST;
            end
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            start_q <= start_d;
            for (int c = 0; c < NCH; c++) begin
                cfg_q[c] <= cfg_d[c];
                sv_q[c] <= sv_d[c];
                err_hi_q[c] <= err_hi_d[c];
                err_lo_q[c] <= err_lo_d[c];
            end
        end
    end

    // Global cancel sources
    assign pf_long = (pf_cnt_q == PF_CW'(PFAIL_CYC));
    assign mod_change = (present_q != peer_in.present);
    assign global_cancel = pf_long || halt_q || mod_change;

    always_comb begin
        present_d = peer_in.present;
        halt_d = fault_halt;
        pf_cnt_d = '0;
        if (power_low) begin
            pf_cnt_d = pf_long ? pf_cnt_q : pf_cnt_q + PF_CW'(1);
        end
    end

    // Group summaries
    always_comb begin
        logic [3:0] g;
        g = 4'h0;
        local_ok = '1;
        local_cancel = '0;
        grp_reached = '1;
        for (int c = 0; c < NCH; c++) begin
            g = cfg_q[c].group;
            if (!qual[c]) begin
                local_ok[g] = 1'b0;
            end
            if (st_q[c] != ST_IDLE && cancel_cond[c]) begin
                local_cancel[g] = 1'b1;
            end
            if (st_q[c] == ST_RISE && !reached[c]) begin
                grp_reached[g] = 1'b0;
            end
        end
        local_ok[0] = 1'b0;
        grp_ok = local_ok & peer_in.ready;
        grp_cancel = local_cancel | peer_in.cancel | {NGRP{global_cancel}};
    end

    // Slowest local channel per group, unless a peer already leads
    always_comb begin
        is_master = '0;
        for (int c = 0; c < NCH; c++) begin
            is_master[c] = !peer_in.master[cfg_q[c].group];
            for (int o = 0; o < NCH; o++) begin
                if (o != c && cfg_q[o].group == cfg_q[c].group && st_q[o] == ST_ARM
                    && ((chan_in[o].rise_time > chan_in[c].rise_time)
                        || (chan_in[o].rise_time == chan_in[c].rise_time && o < c))) begin
                    is_master[c] = 1'b0;
                end
            end
        end
    end

    assign lag_done = (lag_cnt_q == LAG_CW'(LAG_CYC - 1));

    // Channel sequencing
    always_comb begin
        logic [3:0] g;
        g = 4'h0;
        any_arm = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            g = cfg_q[c].group;
            st_d[c] = st_q[c];
            master_d[c] = master_q[c];
            unique case (st_q[c])
                ST_IDLE: begin
                    master_d[c] = 1'b0;
                    if (start_q && grp_ok[g] && !grp_cancel[g]) begin
                        st_d[c] = ST_ARM;
                    end
                end
                ST_ARM: begin
                    any_arm = 1'b1;
                    if (grp_cancel[g]) begin
                        st_d[c] = ST_IDLE;
                    end else if (lag_done) begin
                        if (grp_ok[g]) begin
                            st_d[c] = ST_RISE;
                            master_d[c] = is_master[c];
                        end else begin
                            st_d[c] = ST_IDLE;
                        end
                    end
                end
                ST_RISE: begin
                    if (grp_cancel[g] || grp_reached[g]) begin
                        st_d[c] = ST_IDLE;
                        master_d[c] = 1'b0;
                    end
                end
                default: begin
                    st_d[c] = ST_IDLE;
                    master_d[c] = 1'b0;
                end
            endcase
        end
        lag_cnt_d = '0;
        if (any_arm && !start_q && !lag_done) begin
            lag_cnt_d = lag_cnt_q + LAG_CW'(1);
        end
        for (int c = 0; c < NCH; c++) begin
            active_d[c] = (st_d[c] == ST_RISE);
        end
        peer_out_d.ready = local_ok;
        peer_out_d.cancel = local_cancel | {NGRP{global_cancel}};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                st_q[c] <= ST_IDLE;
            end
            master_q <= '0;
            active_q <= '0;
            lag_cnt_q <= '0;
            pf_cnt_q <= '0;
            present_q <= '0;
            halt_q <= 1'b0;
            peer_out_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                st_q[c] <= st_d[c];
            end
            master_q <= master_d;
            active_q <= active_d;
            lag_cnt_q <= lag_cnt_d;
            pf_cnt_q <= pf_cnt_d;
            present_q <= present_d;
            halt_q <= halt_d;
            peer_out_q <= peer_out_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign peer_out = peer_out_q;
    assign sync_active = active_q;
    assign sync_master = master_q;

endmodule : gtrsc_top

`default_nettype wire
